/* File: pcmp_regs.vh */
// Register map, field codes and timing constants of the position compare unit
//
// Summary of operation
// - Compare switch value 1 enables comparison; any other value keeps it off.
// - Resolution code 0..7 scales positions from 24-bit down to 17-bit per revolution.
// - Mode 0 is individual single pass, mode 1 is cyclic comparison.
// - Writing 1 to take-position-as-zero makes the present position the zero point.
// - On that zeroing the live position loads the signed zero offset, not zero.
// - A matched point holds the output for width times 0.1 ms, width 0 to 2047.
// - A new first point index applies only when the switch is next set to 1.
// - A new last point index applies only when the switch is next set to 1.
// - Status reads 0 when idle, otherwise the number of the awaited point.
// - Live signed 32-bit compare position is readable while comparison runs.
// - Each point holds a signed 32-bit target position.
// - Attribute 0 skips a point and gives no output for it.
// - Attribute 1 fires upward, 2 downward, 3 on either crossing.
// - Switch 0 to 1 starts at the first point; back to 0 stops and clears status.
// - Individual mode stops and clears status at the last point; position keeps accumulating.
// - Cyclic mode wraps to the first point and zeroes position at each reached point.
// - No comparison is done while the output pulse is active.
`ifndef PCMP_REGS_VH
`define PCMP_REGS_VH

// Word addresses of the registers
`define PCMP_ADDR_SWITCH     5'h00
`define PCMP_ADDR_RES        5'h01
`define PCMP_ADDR_MODE       5'h02
`define PCMP_ADDR_ZERO       5'h03
`define PCMP_ADDR_WIDTH      5'h04
`define PCMP_ADDR_FIRST      5'h05
`define PCMP_ADDR_LAST       5'h06
`define PCMP_ADDR_STATUS     5'h07
`define PCMP_ADDR_LIVE       5'h08
`define PCMP_ADDR_OFFSET     5'h09
`define PCMP_ADDR_POINT_BASE 5'h0a
`define PCMP_ADDR_WIDTH_BITS 5

// Field codes
`define PCMP_SWITCH_ON       16'h0001
`define PCMP_ZERO_ON         16'h0001
`define PCMP_MODE_CYCLIC     16'h0001
`define PCMP_ATTR_SKIP       2'h0
`define PCMP_ATTR_UP         2'h1
`define PCMP_ATTR_DOWN       2'h2
`define PCMP_ATTR_BOTH       2'h3
`define PCMP_RES_BITS        3
`define PCMP_WIDTH_FIELD     11
`define PCMP_ATTR_BITS       2

// Reset values
`define PCMP_RST_HALF        16'h0000
`define PCMP_RST_WORD        32'h00000000
`define PCMP_RST_FIRST       16'h0001
`define PCMP_RST_LAST        16'h0001

// Timing: width unit is 0.1 ms, clock period 5 ns
`define PCMP_UNIT_NS         100000
`define PCMP_CLK_NS          5

`endif

/* File: pcmp_pulse_timer.v */
// Output pulse timer counting whole 0.1 ms units
`timescale 1ns/1ps
module pcmp_pulse_timer #(
  parameter TICK_CYCLES = 20000,            // clocks per width unit
  parameter WBITS       = 11                // width of the unit count
) (
  input  wire             clk,              // system clock
  input  wire             resetn,           // synchronous reset, low active
  input  wire             ce,               // clock enable
  input  wire             start,            // load a new pulse
  input  wire [WBITS-1:0] width,            // pulse length in units
  output reg              active_q          // pulse output
);

  reg [WBITS-1:0] unitsLeft_q;
  reg [31:0]      tick_q;

  // Count units down while the pulse stands
  always @(posedge clk) begin
    if (!resetn) begin
      active_q    <= 1'b0;
      unitsLeft_q <= {WBITS{1'b0}};
      tick_q      <= 32'h00000000;
    end else if (ce) begin
      if (start && !active_q) begin
        active_q    <= (width != {WBITS{1'b0}});
        unitsLeft_q <= width;
        tick_q      <= 32'h00000000;
      end else if (active_q) begin
        if (tick_q == TICK_CYCLES - 1) begin
          tick_q <= 32'h00000000;
          if (unitsLeft_q == {{(WBITS-1){1'b0}}, 1'b1}) begin
            active_q <= 1'b0;
          end
          unitsLeft_q <= unitsLeft_q - {{(WBITS-1){1'b0}}, 1'b1};
        end else begin
          tick_q <= tick_q + 32'h00000001;
        end
      end
    end
  end

endmodule // pcmp_pulse_timer

/* File: pcmp_core.v */
// Position compare unit: register file, position tracking and point sequencer
`timescale 1ns/1ps
`include "pcmp_regs.vh"
module pcmp_core #(
  parameter NPOINTS     = 4,                // number of compare points
  parameter TICK_CYCLES = (`PCMP_UNIT_NS + `PCMP_CLK_NS - 1) / `PCMP_CLK_NS
) (
  input  wire        clk,                   // 200 MHz clock
  input  wire        resetn,                // synchronous reset, low active
  input  wire        ce,                    // clock enable, freezes all state
  input  wire [4:0]  addr,                  // register word address
  input  wire [31:0] wdata,                 // write data
  input  wire        wr,                    // write strobe
  input  wire        rd,                    // read strobe
  output reg  [31:0] rdata_q,               // read data, cycle after rd
  input  wire [31:0] encPos,                // encoder position, 24-bit units
  input  wire        encToggle,             // toggles on each new encoder sample
  output wire        cmpOut                 // compare output pulse
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;
  localparam RAWW    = 40;                  // accumulator with 8 guard bits

  // Accumulator keeps 24-bit units, so a resolution change acts on
  // the next sample and stored position is never rescaled.
  // The guard bits stop the sum from wrapping before the shift,
  // and the low 32 bits of the shifted value form the live view.
  // Offsets shifted by the resolution keep their sign.

  // Software registers
  reg [15:0] switch_q;
  reg [2:0]  res_q;
  reg [15:0] mode_q;
  reg [15:0] zero_q;
  reg [10:0] width_q;
  reg [15:0] first_q;
  reg [15:0] last_q;
  reg [31:0] offset_q;
  reg [31:0] target_q [0:NPOINTS-1];
  reg [1:0]  attr_q   [0:NPOINTS-1];

  // Sequencer state; run bounds latched at start
  // Index writes during a run wait for the next switch-on
  reg            state_q;
  reg [15:0]     curIdx_q;
  reg [15:0]     runFirst_q;
  reg [15:0]     runLast_q;
  reg            switchOn_q;
  reg            zeroOn_q;
  reg signed [RAWW-1:0] raw_q;
  reg signed [31:0]     live_q;

  // Encoder input synchronisers
  // Word and toggle each pass two flops before logic reads them
  reg [31:0] encS1_q;
  reg [31:0] encS2_q;
  reg        togS1_q;
  reg        togS2_q;
  reg        togS3_q;
  reg [31:0] encPrev_q;
  reg        encPrimed_q;

  wire       timerActive;
  reg        fire;

  // Register writes
  // Status and live position are read-only; their writes are dropped
  always @(posedge clk) begin
    if (!resetn) begin
      switch_q <= `PCMP_RST_HALF;
      res_q    <= {`PCMP_RES_BITS{1'b0}};
      mode_q   <= `PCMP_RST_HALF;
      zero_q   <= `PCMP_RST_HALF;
      width_q  <= {`PCMP_WIDTH_FIELD{1'b0}};
      first_q  <= `PCMP_RST_FIRST;
      last_q   <= `PCMP_RST_LAST;
      offset_q <= `PCMP_RST_WORD;
    end else if (ce && wr) begin
      if (addr == `PCMP_ADDR_SWITCH) begin
        switch_q <= wdata[15:0];
      end else if (addr == `PCMP_ADDR_RES) begin
        res_q <= wdata[`PCMP_RES_BITS-1:0];
      end else if (addr == `PCMP_ADDR_MODE) begin
        mode_q <= wdata[15:0];
      end else if (addr == `PCMP_ADDR_ZERO) begin
        zero_q <= wdata[15:0];
      end else if (addr == `PCMP_ADDR_WIDTH) begin
        width_q <= wdata[`PCMP_WIDTH_FIELD-1:0];
      end else if (addr == `PCMP_ADDR_FIRST) begin
        first_q <= wdata[15:0];
      end else if (addr == `PCMP_ADDR_LAST) begin
        last_q <= wdata[15:0];
      end else if (addr == `PCMP_ADDR_OFFSET) begin
        offset_q <= wdata;
      end
    end
  end

  // Per-point target and attribute storage
  genvar gi;
  generate
    for (gi = 0; gi < NPOINTS; gi = gi + 1) begin : gPoint
      wire [`PCMP_ADDR_WIDTH_BITS-1:0] tAddr;
      wire [`PCMP_ADDR_WIDTH_BITS-1:0] aAddr;
      localparam [31:0] TOFS = `PCMP_ADDR_POINT_BASE + 2 * gi;
      localparam [31:0] AOFS = `PCMP_ADDR_POINT_BASE + 2 * gi + 1;
      // Offsets cut to the address width on purpose
      assign tAddr = TOFS[`PCMP_ADDR_WIDTH_BITS-1:0];
      assign aAddr = AOFS[`PCMP_ADDR_WIDTH_BITS-1:0];
      always @(posedge clk) begin
        if (!resetn) begin
          target_q[gi] <= `PCMP_RST_WORD;
          attr_q[gi]   <= `PCMP_ATTR_SKIP;
        end else if (ce && wr) begin
          if (addr == tAddr) begin
            target_q[gi] <= wdata;
          end else if (addr == aAddr) begin
            attr_q[gi] <= wdata[`PCMP_ATTR_BITS-1:0];
          end
        end
      end
    end
  endgenerate

  // Read mux, data stands the cycle after the strobe
  // Unmapped words read zero; narrow fields read zero above their top
  reg [31:0] rdMux;
  integer    ri;
  always @* begin
    rdMux = 32'h00000000;
    if (addr == `PCMP_ADDR_SWITCH) begin
      rdMux = {16'h0000, switch_q};
    end else if (addr == `PCMP_ADDR_RES) begin
      rdMux = {29'h00000000, res_q};
    end else if (addr == `PCMP_ADDR_MODE) begin
      rdMux = {16'h0000, mode_q};
    end else if (addr == `PCMP_ADDR_ZERO) begin
      rdMux = {16'h0000, zero_q};
    end else if (addr == `PCMP_ADDR_WIDTH) begin
      rdMux = {21'h000000, width_q};
    end else if (addr == `PCMP_ADDR_FIRST) begin
      rdMux = {16'h0000, first_q};
    end else if (addr == `PCMP_ADDR_LAST) begin
      rdMux = {16'h0000, last_q};
    end else if (addr == `PCMP_ADDR_STATUS) begin
      rdMux = {16'h0000, curIdx_q};
    end else if (addr == `PCMP_ADDR_LIVE) begin
      rdMux = live_q;
    end else if (addr == `PCMP_ADDR_OFFSET) begin
      rdMux = offset_q;
    end else begin
      for (ri = 0; ri < NPOINTS; ri = ri + 1) begin
        if (addr == `PCMP_ADDR_POINT_BASE + 2 * ri) begin
          rdMux = target_q[ri];
        end else if (addr == `PCMP_ADDR_POINT_BASE + 2 * ri + 1) begin
          rdMux = {30'h00000000, attr_q[ri]};
        end
      end
    end
  end

  // Read data register, zero outside the cycle after a read
  always @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= `PCMP_RST_WORD;
    end else if (ce) begin
      rdata_q <= rd ? rdMux : `PCMP_RST_WORD;
    end
  end

  // Two-stage synchroniser for encoder word and sample toggle
  // The word settles a clock before the toggle edge is seen,
  // so the whole word is stable when a sample is taken
  always @(posedge clk) begin
    if (!resetn) begin
      encS1_q <= `PCMP_RST_WORD;
      encS2_q <= `PCMP_RST_WORD;
      togS1_q <= 1'b0;
      togS2_q <= 1'b0;
      togS3_q <= 1'b0;
    end else if (ce) begin
      encS1_q <= encPos;
      encS2_q <= encS1_q;
      togS1_q <= encToggle;
      togS2_q <= togS1_q;
      togS3_q <= togS2_q;
    end
  end

  // One-clock event for each change of the sample toggle
  wire newSample = togS2_q ^ togS3_q;

  // Position accumulation in encoder units, scaled by resolution
  // Deltas wrap in 32 bits, so encoder rollover adds no jump;
  // the first sample after reset only primes the previous word
  wire [31:0]            encDelta = encS2_q - encPrev_q;
  wire signed [RAWW-1:0] rawSum   = raw_q + {{(RAWW-32){encDelta[31]}}, encDelta};
  wire signed [RAWW-1:0] rawShift = rawSum >>> res_q;
  wire signed [31:0]     liveNew  = rawShift[31:0];

  // Crossing detection for the awaited point
  // Only the awaited point is compared; a sample that jumps past
  // a later point does not fire it. A position resting on the
  // target fires once, as the previous value no longer differs.
  wire [15:0]        idx0   = curIdx_q - 16'h0001;
  wire signed [31:0] tgt    = target_q[idx0[1:0]];
  wire [1:0]         attr   = attr_q[idx0[1:0]];
  wire               upX    = (live_q < tgt) && (liveNew >= tgt);
  wire               downX  = (live_q > tgt) && (liveNew <= tgt);
  wire               isSkip = (attr == `PCMP_ATTR_SKIP);
  wire               atLast = (curIdx_q == runLast_q);
  wire               cyclic = (mode_q == `PCMP_MODE_CYCLIC);
  wire               swOn   = (switch_q == `PCMP_SWITCH_ON);
  wire               zrOn   = (zero_q == `PCMP_ZERO_ON);
  wire               canCmp = (state_q == ST_RUN) && !timerActive;

  // Rising edges of the switch and zero controls
  wire               swStart = swOn && !switchOn_q;
  wire               zrStart = zrOn && !zeroOn_q;

  // Match on the enabled crossing direction
  // Nothing is compared while the pulse stands, so a crossing in
  // that time is lost; travel between points must outlast the pulse
  always @* begin
    fire = 1'b0;
    if (canCmp && newSample && encPrimed_q) begin
      case (attr)
        `PCMP_ATTR_UP:   fire = upX;
        `PCMP_ATTR_DOWN: fire = downX;
        `PCMP_ATTR_BOTH: fire = upX || downX;
        default:         fire = 1'b0;
      endcase
    end
  end

  // Skipped points advance one per clock without a sample
  // A fired point advances in the clock of the crossing
  wire advance = canCmp && (isSkip || fire);

  // Position register and zero handling
  // Zeroing wins over a sample in the same clock; that sample is
  // absorbed by re-priming the previous word
  always @(posedge clk) begin
    if (!resetn) begin
      raw_q       <= {RAWW{1'b0}};
      live_q      <= `PCMP_RST_WORD;
      encPrev_q   <= `PCMP_RST_WORD;
      encPrimed_q <= 1'b0;
      zeroOn_q    <= 1'b0;
    end else if (ce) begin
      zeroOn_q <= zrOn;
      if (zrStart) begin
        raw_q  <= {{(RAWW-32){offset_q[31]}}, offset_q} <<< res_q;
        live_q <= offset_q;
        encPrev_q <= encS2_q;
      end else if (newSample) begin
        encPrev_q   <= encS2_q;
        encPrimed_q <= 1'b1;
        if (!encPrimed_q) begin
          raw_q <= raw_q;
        end else if (fire && cyclic) begin
          raw_q  <= {RAWW{1'b0}};
          live_q <= `PCMP_RST_WORD;
        end else begin
          raw_q  <= rawSum;
          live_q <= liveNew;
        end
      end
    end
  end

  // Point sequencer
  // First and last indices are assumed within 1..NPOINTS with
  // first not above last; out of range values are not checked
  // and the low bits of the index pick the point
  always @(posedge clk) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      curIdx_q   <= `PCMP_RST_HALF;
      runFirst_q <= `PCMP_RST_FIRST;
      runLast_q  <= `PCMP_RST_LAST;
      switchOn_q <= 1'b0;
    end else if (ce) begin
      switchOn_q <= swOn;
      case (state_q)
        ST_IDLE: begin
          if (swStart) begin
            state_q    <= ST_RUN;
            runFirst_q <= first_q;
            runLast_q  <= last_q;
            curIdx_q   <= first_q;
          end
        end
        ST_RUN: begin
          if (!swOn) begin
            state_q  <= ST_IDLE;
            curIdx_q <= `PCMP_RST_HALF;
          end else if (advance) begin
            if (!atLast) begin
              curIdx_q <= curIdx_q + 16'h0001;
            end else if (cyclic) begin
              curIdx_q <= runFirst_q;
            end else begin
              state_q  <= ST_IDLE;
              curIdx_q <= `PCMP_RST_HALF;
            end
          end
        end
        // Unused state code falls back to idle
        default: begin
          state_q  <= ST_IDLE;
          curIdx_q <= `PCMP_RST_HALF;
        end
      endcase
    end
  end

  // Output pulse of programmed width
  // Width 0 gives no pulse, yet the point still counts as reached.
  // The timer ignores a start while its pulse stands, which the
  // sequencer already prevents by suspending comparison.
  pcmp_pulse_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .WBITS       (`PCMP_WIDTH_FIELD)
  ) uTimer (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .start    (fire),
    .width    (width_q),
    .active_q (timerActive)
  );

  // Output taken straight from the timer flop, no logic after it
  // so the pin never glitches between clocks
  assign cmpOut = timerActive;

endmodule // pcmp_core

/* File: pcmp_core_monitor.sv */
// Port checker for the position compare unit
`timescale 1ns/1ps
module pcmp_core_monitor #(
  parameter NPOINTS     = 4,     // compare points
  parameter TICK_CYCLES = 20000  // clocks per width unit
) (
  input wire        clk,         // clock
  input wire        resetn,      // sync reset
  input wire        ce,          // clock enable
  input wire [4:0]  addr,        // address
  input wire [31:0] wdata,       // write data
  input wire        wr,          // write strobe
  input wire        rd,          // read strobe
  input wire [31:0] rdata_q,     // read data
  input wire [31:0] encPos,      // encoder position
  input wire        encToggle,   // sample event
  input wire        cmpOut       // output pulse
);
  reg [10:0] widthShadow_q;      // accepted width
  reg [15:0] swShadow_q;         // accepted switch
  reg [31:0] pulseCnt_q;         // pulse length so far
  reg [3:0]  sinceTog_q;         // clocks since sample
  reg        togPrev_q;          // last toggle level
  // Shadows of written values and cycle counters
  always @(posedge clk) begin
    if (!resetn) begin
      widthShadow_q <= 11'h0;
      swShadow_q <= 16'h0;
      pulseCnt_q <= 32'h0;
      sinceTog_q <= 4'hf;
      togPrev_q <= encToggle;
    end else if (ce) begin
      if (wr && addr == 5'h04) widthShadow_q <= wdata[10:0];
      if (wr && addr == 5'h00) swShadow_q <= wdata[15:0];
      pulseCnt_q <= cmpOut ? pulseCnt_q + 32'h1 : 32'h0;
      togPrev_q <= encToggle;
      if (encToggle != togPrev_q) sinceTog_q <= 4'h0;
      else if (sinceTog_q != 4'hf) sinceTog_q <= sinceTog_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rst_quiet;
    disable iff (1'b0) !resetn && ce |=> !cmpOut && rdata_q == 32'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active after reset");
  property p_rdata_idle;
    ce && !rd |=> rdata_q == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without read");
  property p_pulse_len;
    $fell(cmpOut) |-> pulseCnt_q == widthShadow_q * TICK_CYCLES;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse length wrong");
  property p_no_zero_pulse;
    $rose(cmpOut) |-> widthShadow_q != 11'h0;
  endproperty
  a_no_zero_pulse: assert property (p_no_zero_pulse)
    else $error("pulse with width 0");
  property p_readback;
    (ce && wr && (addr == 5'h09 || addr == 5'h0a)) ##1 (ce && rd && addr == $past(addr))
      |=> rdata_q == $past(wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback differs");
  property p_status_off;
    ce && rd && addr == 5'h07 && swShadow_q != 16'h1 |=> rdata_q == 32'h0;
  endproperty
  a_status_off: assert property (p_status_off)
    else $error("status nonzero while off");
  property p_rise_after_sample;
    $rose(cmpOut) |-> sinceTog_q >= 4'h1 && sinceTog_q <= 4'h8;
  endproperty
  a_rise_after_sample: assert property (p_rise_after_sample)
    else $error("pulse without sample");
  property p_rise_needs_switch;
    $rose(cmpOut) |-> swShadow_q == 16'h1;
  endproperty
  a_rise_needs_switch: assert property (p_rise_needs_switch)
    else $error("pulse while switch off");
  c_rise: cover property ($rose(cmpOut));
  c_fell: cover property ($fell(cmpOut));
  c_readback: cover property (ce && wr && addr == 5'h09 ##1 ce && rd && addr == 5'h09);
endmodule // pcmp_core_monitor

bind pcmp_core pcmp_core_monitor #(.NPOINTS(NPOINTS), .TICK_CYCLES(TICK_CYCLES))
  pcmp_core_monitor_inst (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_q(rdata_q), .encPos(encPos), .encToggle(encToggle),
  .cmpOut(cmpOut));

/* File: pcmp_enc_model.sv */
// Encoder feedback model presenting position samples
`timescale 1ns/1ps
module pcmp_enc_model (
  input  wire        clk,      // clock
  input  wire        go,       // new sample request
  input  wire [31:0] pos,      // position to present
  output reg  [31:0] encPos,   // held position
  output reg         encToggle // sample event
);
  reg pend_q = 1'b0;           // toggle pending
  initial begin
    encPos = 32'h0;
    encToggle = 1'b0;
  end
  // Position first, toggle a clock later, position then held
  always @(posedge clk) begin
    pend_q <= go;
    if (go) encPos <= pos;
    if (pend_q) encToggle <= ~encToggle;
  end
endmodule // pcmp_enc_model

/* File: pcmp_core_tb.sv */
// Self-checking bench for the position compare unit
`timescale 1ns/1ps
module pcmp_core_tb;
  localparam TICK = 4;
  localparam W = 2;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg        ce = 1'b1;
  reg [4:0]  addr = 5'h0;
  reg [31:0] wdata = 32'h0;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg        go = 1'b0;
  reg [31:0] pos = 32'h0;
  reg [31:0] seed = 32'h21183ca0;
  wire [31:0] rdata_q;
  wire [31:0] encPos;
  wire       encToggle;
  wire       cmpOut;
  integer    err_total = 0;
  integer    num_checks = 0;
  integer    i;
  pcmp_core #(.NPOINTS(4), .TICK_CYCLES(TICK)) pcmp_core_inst (.clk(clk), .resetn(resetn),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .encPos(encPos), .encToggle(encToggle), .cmpOut(cmpOut));
  pcmp_enc_model pcmp_enc_model_inst (.clk(clk), .go(go), .pos(pos), .encPos(encPos),
    .encToggle(encToggle));
  // Clock
  always #2.5 clk = ~clk;
  function [31:0] lfsrNext(input [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] regMask(input [4:0] a);
    regMask = (a == 5'h01) ? 32'h7 : (a == 5'h04) ? 32'h7ff :
      (a[0] && a > 5'h0a) ? 32'h3 : 32'hffffffff;
  endfunction
  task chk32(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chkLen(input integer got, input integer exp);
    num_checks = num_checks + 1;
    if (got != exp) begin
      err_total = err_total + 1;
      $display("Error t=%0t len=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrReg(input [4:0] a, input [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdReg(input [4:0] a, input [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk32(rdata_q, exp);
  endtask
  // Write then read back with no gap
  task wrRd(input [4:0] a, input [31:0] d, input [31:0] exp);
    wrReg(a, d);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk32(rdata_q, exp);
  endtask
  // New encoder sample, then measure any output pulse
  task step(input [31:0] p, input fire);
    integer n;
    integer k;
    begin
      n = 0;
      @(posedge clk);
      go <= 1'b1;
      pos <= p;
      @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 40; k = k + 1) begin
        @(posedge clk);
        #1;
        if (cmpOut === 1'b1) n = n + 1;
      end
      chkLen(n, fire ? W * TICK : 0);
    end
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total = err_total + 1;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    step(32'h0, 1'b0);
    rdReg(5'h07, 32'h0);
    rdReg(5'h1f, 32'h0);
    wrReg(5'h07, 32'h3);
    rdReg(5'h07, 32'h0);
    for (i = 1; i < 18; i = i + 1) begin
      if (i == 1 || i == 4 || i > 8) begin
        seed = lfsrNext(seed);
        wrRd(i[4:0], seed, seed & regMask(i[4:0]));
      end
    end
    // Individual pass over four points
    wrReg(5'h01, 32'h0);
    wrReg(5'h02, 32'h0);
    wrReg(5'h04, W);
    wrReg(5'h0a, 32'd100);
    wrReg(5'h0b, 32'h1);
    wrReg(5'h0c, 32'd50);
    wrReg(5'h0d, 32'h2);
    wrReg(5'h0f, 32'h0);
    wrReg(5'h10, 32'd200);
    wrReg(5'h11, 32'h3);
    wrReg(5'h05, 32'h1);
    wrReg(5'h06, 32'h4);
    wrReg(5'h00, 32'h2);
    rdReg(5'h07, 32'h0);
    wrReg(5'h00, 32'h0);
    wrReg(5'h00, 32'h1);
    rdReg(5'h07, 32'h1);
    step(32'd150, 1'b1);
    rdReg(5'h07, 32'h2);
    step(32'd40, 1'b1);
    rdReg(5'h07, 32'h4);
    step(32'd250, 1'b1);
    rdReg(5'h07, 32'h0);
    rdReg(5'h08, 32'hfa);
    // Zero offset and resolution
    wrReg(5'h01, 32'h2);
    wrReg(5'h09, 32'hfffffffb);
    wrReg(5'h03, 32'h0);
    wrReg(5'h03, 32'h1);
    rdReg(5'h08, 32'hfffffffb);
    step(32'd650, 1'b0);
    rdReg(5'h08, 32'h5f);
    // Cyclic run over points 2 and 3
    wrReg(5'h01, 32'h0);
    wrReg(5'h02, 32'h1);
    wrReg(5'h00, 32'h0);
    wrReg(5'h0c, 32'd10);
    wrReg(5'h0d, 32'h1);
    wrReg(5'h0e, 32'hfffffff6);
    wrReg(5'h0f, 32'h2);
    wrReg(5'h05, 32'h2);
    wrReg(5'h06, 32'h3);
    wrReg(5'h09, 32'h0);
    wrReg(5'h03, 32'h0);
    wrReg(5'h03, 32'h1);
    wrReg(5'h00, 32'h1);
    rdReg(5'h07, 32'h2);
    wrReg(5'h05, 32'h1);
    wrReg(5'h06, 32'h2);
    step(32'd630, 1'b0);
    rdReg(5'h07, 32'h2);
    step(32'd660, 1'b1);
    rdReg(5'h08, 32'h0);
    rdReg(5'h07, 32'h3);
    step(32'd640, 1'b1);
    rdReg(5'h07, 32'h2);
    wrReg(5'h00, 32'h0);
    rdReg(5'h07, 32'h0);
    wrReg(5'h00, 32'h1);
    rdReg(5'h07, 32'h1);
    // Writes ignored while the clock enable is low
    ce <= 1'b0;
    wrReg(5'h04, 32'h5);
    ce <= 1'b1;
    rdReg(5'h04, W);
    test_done;
  end
endmodule // pcmp_core_tb
